// >>> include/msd_defines.svh
// Purpose: constants of the motor driver serial port and diagnostics
// Assumes: 100 MHz system clock
// Notes: offsets are register indices of the serial protocol
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

// Command codes and field positions of the first byte
`define MSD_CMD_READ 3'h0
`define MSD_CMD_WRITE 3'h4
`define MSD_CMD_MSB 7
`define MSD_CMD_LSB 5
`define MSD_ADDR_MSB 4

// Register indices
`define MSD_IDX_CR0 5'h01
`define MSD_IDX_CR1 5'h02
`define MSD_IDX_CR2 5'h03
`define MSD_IDX_ST0 5'h04
`define MSD_IDX_ST1 5'h05
`define MSD_IDX_ST2 5'h06
`define MSD_IDX_ST3 5'h07

// Control register 2 fields and reset value
`define MSD_CR2_MOTEN 7
`define MSD_CR2_SLEEP 6
`define MSD_CR2_DIV 5
`define MSD_CR2_TRANS 4
`define MSD_CR_RESET 8'h00

// Packet length of a write
`define MSD_WR_BITS 6'h10
`define MSD_TOTAL_MAX 6'h3f

// Timing
`define MSD_CLK_MHZ 100
`define MSD_CLK_NS 10
`define MSD_OPEN_TIME_MS 32
`define MSD_OPEN_CYCLES (`MSD_OPEN_TIME_MS * 1000 * `MSD_CLK_MHZ)
`define MSD_CLR_MIN_NS 100
`define MSD_CLR_CYCLES ((`MSD_CLR_MIN_NS + `MSD_CLK_NS - 1) / `MSD_CLK_NS)

`endif

// >>> include/msd_pkg.sv
// Purpose: types of the motor driver serial port and diagnostics
// Assumes: nothing beyond the defines header
// Notes: flag record is what status bytes ST0 to ST2 are built from
`default_nettype none
package msd_pkg;

    // Latched diagnostic flags
    typedef struct packed {
        logic therm_warn;
        logic therm_shut;
        logic [3:0] ovc_x;
        logic [3:0] ovc_y;
        logic open_x;
        logic open_y;
        logic pump_fail;
    } msd_flags_t;

    // Byte phase inside a packet
    typedef enum logic [1:0] {
        MSD_IDLE,
        MSD_CMD,
        MSD_DATA
    } msd_phase_t;

endpackage
`default_nettype wire

// >>> logic/msd_spi_diag.sv
// Purpose: serial slave port, control registers and fault flags
// Assumes: serial clock well below clk/4, analog inputs are levels
// Notes: all pins except coil voltage and step position are resampled, serial edges found in clk domain
`include "msd_defines.svh"
`default_nettype none

// Overview of operation
// - Back-EMF sampled at every coil zero crossing, four points per period.
// - Transparent select follows coil voltage; else holds end-of-interval sample.
// - Sampled coil voltage scaled by one half or one quarter.
// - Warning comparator sets the thermal warning flag.
// - Shutdown sets flag, drivers off; clears after cooling and a read.
// - Overcurrent latches per-transistor flag, drivers stay off until cleared.
// - Full duty beyond 32 ms sets open coil flag, current kept.
// - Pump fail flag held high while pump voltage is low.
// - Open-drain low fault pin asserted while any flag set.
// - Hard reset held long enough clears registers, except in sleep.
// - Sleep: drivers off, registers kept, step inputs ignored, port alive.
// - Device is only a serial slave, never starts transfers.
// - Data out shifts on falling, data in sampled on rising edge.
// - Data out released while chip select inactive.
// - Every eighth falling edge loads addressed register into output.
// - Registers updated on first system clock edge with select high.
// - Bytes shifted MSB first; packets of one or more bytes, full duplex.
// - First byte: three-bit command, five-bit index; second byte data.
// - Command 000 reads, command 100 writes.
// - Write packets must be exactly sixteen clocks, others discarded.
// - Write data committed only after chip select returns high.
// - Status byte top bit is XOR of lower seven bits, so each byte has even parity.
// - Latched status flags cleared after a status register is read.
module msd_spi_diag
    import msd_pkg::*;
#(
    parameter int OPEN_CYCLES = `MSD_OPEN_CYCLES,
    parameter int CLR_CYCLES = `MSD_CLR_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic hard_reset_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input wire logic thermal_warn_in,
    input wire logic thermal_shutdown_in,
    input wire logic [3:0] overcurrent_x_in,
    input wire logic [3:0] overcurrent_y_in,
    input wire logic full_duty_x_in,
    input wire logic full_duty_y_in,
    input wire logic pump_low_in,
    input wire logic [1:0] coil_zero_in,
    input wire logic pwm_sample_hold,
    input wire logic [7:0] coil_voltage_in,
    input wire logic [6:0] step_position_in,
    input wire logic step_advance_in,
    input wire logic rotation_sense_in,
    output logic [7:0] speed_load_angle_out,
    output logic fault_out_n,
    output logic fault_out_n_oe,
    output logic drivers_hiz,
    output logic step_advance_out,
    output logic rotation_sense_out,
    output logic clocks_run,
    output logic sleep_ctrl,
    output logic bemf_transparent_sel,
    output logic bemf_divider_sel,
    output logic motor_enable,
    output logic [7:0] ctrl0_out,
    output logic [7:0] ctrl1_out
);

    localparam int NS = 22;
    localparam logic [NS-1:0] SYNC_RST = 22'h080000; // Select idles high
    localparam int OW = $clog2(OPEN_CYCLES + 1);
    localparam logic [OW-1:0] OPEN_LAST = OW'(OPEN_CYCLES - 1);
    localparam logic [15:0] CLR_LAST = 16'(CLR_CYCLES - 1);

    logic [NS-1:0] async_in, sync1_r, sync2_r;
    logic hr_s, sclk_s, cs_s, mosi_s, warn_s, shut_s, fx_s, fy_s, pl_s;
    logic psh_s, step_s, rot_s;
    logic [3:0] ox_s, oy_s;
    logic [1:0] zero_s, zero_prev_r;
    logic sclk_prev_r, cs_prev_r, sclk_rise, sclk_fall, cs_rise, cs_fall;
    logic [15:0] hr_cnt_r, hr_cnt_nxt;
    logic hr_active_r, hr_active_nxt, rst;

    // Pins come from other domains, so all but coil voltage and step position pass two flops
    assign async_in = {hard_reset_in, sclk_in, cs_n_in, serial_data_in,
                       thermal_warn_in, thermal_shutdown_in, overcurrent_x_in,
                       overcurrent_y_in, full_duty_x_in, full_duty_y_in,
                       pump_low_in, coil_zero_in, pwm_sample_hold,
                       step_advance_in, rotation_sense_in};
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end
    assign {hr_s, sclk_s, cs_s, mosi_s, warn_s, shut_s, ox_s, oy_s, fx_s,
            fy_s, pl_s, zero_s, psh_s, step_s, rot_s} = sync2_r;

    // Edge finders on the second stage only
    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_prev_r <= 1'b0;
            cs_prev_r <= 1'b1;
            zero_prev_r <= 2'h0;
        end else begin
            sclk_prev_r <= sclk_s;
            cs_prev_r <= cs_s;
            zero_prev_r <= zero_s;
        end
    end
    assign sclk_rise = sclk_s && !sclk_prev_r;
    assign sclk_fall = !sclk_s && sclk_prev_r;
    assign cs_rise = cs_s && !cs_prev_r;
    assign cs_fall = !cs_s && cs_prev_r;

    // Hard reset needs its minimum width; sleep shields the registers
    always_comb begin
        hr_cnt_nxt = hr_s ? hr_cnt_r : 16'h0000;
        if (hr_s && hr_cnt_r != CLR_LAST)
            hr_cnt_nxt = hr_cnt_r + 16'h0001;
        hr_active_nxt = hr_s && hr_cnt_r == CLR_LAST && !sleep_ctrl;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            hr_cnt_r <= 16'h0000;
            hr_active_r <= 1'b0;
        end else begin
            hr_cnt_r <= hr_cnt_nxt;
            hr_active_r <= hr_active_nxt;
        end
    end
    assign rst = srst || hr_active_r;

    msd_phase_t phase_r, phase_nxt;
    logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt, rd_byte, byte_in;
    logic [2:0] bit_r, bit_nxt, rd_mark_r, rd_mark_nxt, st_clr_r, st_clr_nxt;
    logic [5:0] total_r, total_nxt;
    logic [4:0] addr_r, addr_nxt, wr_addr_r, wr_addr_nxt;
    logic [7:0] wr_data_r, wr_data_nxt, cr0_r, cr0_nxt, cr1_r, cr1_nxt;
    logic [7:0] cr2_r, cr2_nxt;
    logic wr_first_r, wr_first_nxt;
    msd_flags_t flags_r, flags_nxt;
    logic [7:0] st0, st1, st2, st3;

    // Status bytes carry odd-count parity on top
    assign st0 = {^{flags_r.therm_warn, flags_r.pump_fail, flags_r.open_x,
                    flags_r.open_y}, flags_r.therm_warn, flags_r.pump_fail,
                  flags_r.open_x, flags_r.open_y, 3'h0};
    assign st1 = {^flags_r.ovc_x, flags_r.ovc_x, 3'h0};
    assign st2 = {^{flags_r.therm_shut, flags_r.ovc_y}, flags_r.therm_shut,
                  flags_r.ovc_y, 2'h0};
    assign st3 = {^step_position_in, step_position_in};

    // Read mux, unmapped indices read as zero
    always_comb begin
        case (addr_r)
            `MSD_IDX_CR0: rd_byte = cr0_r;
            `MSD_IDX_CR1: rd_byte = cr1_r;
            `MSD_IDX_CR2: rd_byte = cr2_r;
            `MSD_IDX_ST0: rd_byte = st0;
            `MSD_IDX_ST1: rd_byte = st1;
            `MSD_IDX_ST2: rd_byte = st2;
            `MSD_IDX_ST3: rd_byte = st3;
            default: rd_byte = 8'h00;
        endcase
    end

    // Serial slave: reacts to master edges only, never starts
    always_comb begin
        byte_in = {rx_r[6:0], mosi_s}; // MSB first
        phase_nxt = phase_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        bit_nxt = bit_r;
        total_nxt = total_r;
        addr_nxt = addr_r;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        wr_first_nxt = wr_first_r;
        rd_mark_nxt = rd_mark_r;
        st_clr_nxt = 3'h0;
        cr0_nxt = cr0_r;
        cr1_nxt = cr1_r;
        cr2_nxt = cr2_r;
        if (cs_rise) begin
            // First clk edge with select high applies the packet
            if (total_r == `MSD_WR_BITS && wr_first_r) begin
                case (wr_addr_r)
                    `MSD_IDX_CR0: cr0_nxt = wr_data_r;
                    `MSD_IDX_CR1: cr1_nxt = wr_data_r;
                    `MSD_IDX_CR2: cr2_nxt = wr_data_r;
                    default: ;
                endcase
            end
            st_clr_nxt = rd_mark_r;
            rd_mark_nxt = 3'h0;
            phase_nxt = MSD_IDLE;
            bit_nxt = 3'h0;
            total_nxt = 6'h00;
            wr_first_nxt = 1'b0;
        end else if (cs_fall) begin
            phase_nxt = MSD_CMD;
            bit_nxt = 3'h0;
            total_nxt = 6'h00;
        end else if (!cs_s && sclk_rise) begin
            rx_nxt = byte_in; // Sample on rising edge
            bit_nxt = bit_r + 3'h1;
            if (total_r != `MSD_TOTAL_MAX)
                total_nxt = total_r + 6'h01;
            if (bit_r == 3'h7 && phase_r == MSD_CMD) begin
                if (byte_in[`MSD_CMD_MSB:`MSD_CMD_LSB] == `MSD_CMD_WRITE) begin
                    addr_nxt = byte_in[`MSD_ADDR_MSB:0];
                    wr_addr_nxt = byte_in[`MSD_ADDR_MSB:0];
                    wr_first_nxt = total_r == 6'h07;
                    phase_nxt = MSD_DATA;
                end else if (byte_in[`MSD_CMD_MSB:`MSD_CMD_LSB] ==
                             `MSD_CMD_READ) begin
                    addr_nxt = byte_in[`MSD_ADDR_MSB:0];
                end
            end else if (bit_r == 3'h7 && phase_r == MSD_DATA) begin
                wr_data_nxt = byte_in;
                phase_nxt = MSD_CMD;
            end
        end else if (!cs_s && sclk_fall) begin
            if (bit_r == 3'h0 && total_r != 6'h00) begin
                tx_nxt = rd_byte; // Eighth falling edge reload
                case (addr_r)
                    `MSD_IDX_ST0: rd_mark_nxt[0] = 1'b1;
                    `MSD_IDX_ST1: rd_mark_nxt[1] = 1'b1;
                    `MSD_IDX_ST2: rd_mark_nxt[2] = 1'b1;
                    default: ;
                endcase
            end else begin
                tx_nxt = {tx_r[6:0], 1'b1}; // Shift on falling edge
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_r <= MSD_IDLE;
            rx_r <= 8'h00;
            tx_r <= 8'hff;
            bit_r <= 3'h0;
            total_r <= 6'h00;
            addr_r <= 5'h00;
            wr_addr_r <= 5'h00;
            wr_data_r <= 8'h00;
            wr_first_r <= 1'b0;
            rd_mark_r <= 3'h0;
            st_clr_r <= 3'h0;
            cr0_r <= `MSD_CR_RESET;
            cr1_r <= `MSD_CR_RESET;
            cr2_r <= `MSD_CR_RESET;
        end else begin
            phase_r <= phase_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            bit_r <= bit_nxt;
            total_r <= total_nxt;
            addr_r <= addr_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            wr_first_r <= wr_first_nxt;
            rd_mark_r <= rd_mark_nxt;
            st_clr_r <= st_clr_nxt;
            cr0_r <= cr0_nxt;
            cr1_r <= cr1_nxt;
            cr2_r <= cr2_nxt;
        end
    end

    // Open coil timers, one per coil
    logic [1:0] full_s, open_hit;
    assign full_s = {fx_s, fy_s};
    for (genvar c = 0; c < 2; c++) begin : g_open
        logic [OW-1:0] cnt_r, cnt_nxt;
        always_comb begin
            cnt_nxt = full_s[c] ? cnt_r : '0;
            if (full_s[c] && cnt_r != OPEN_LAST)
                cnt_nxt = cnt_r + OW'(1);
        end
        always_ff @(posedge clk) begin
            if (rst)
                cnt_r <= '0;
            else
                cnt_r <= cnt_nxt;
        end
        assign open_hit[c] = full_s[c] && cnt_r == OPEN_LAST;
    end

    // Sticky flags: a set in the clearing cycle wins
    always_comb begin
        flags_nxt.therm_warn = warn_s ||
            (flags_r.therm_warn && !st_clr_r[0]);
        flags_nxt.pump_fail = pl_s ||
            (flags_r.pump_fail && !st_clr_r[0]);
        flags_nxt.open_x = open_hit[1] ||
            (flags_r.open_x && !st_clr_r[0]);
        flags_nxt.open_y = open_hit[0] || (flags_r.open_y && !st_clr_r[0]);
        flags_nxt.ovc_x = ox_s | (flags_r.ovc_x & {4{!st_clr_r[1]}});
        flags_nxt.ovc_y = oy_s | (flags_r.ovc_y & {4{!st_clr_r[2]}});
        // Cooling below warning level is also needed to drop it
        flags_nxt.therm_shut = shut_s ||
            (flags_r.therm_shut && !(st_clr_r[2] && !warn_s));
    end
    always_ff @(posedge clk) begin
        if (rst)
            flags_r <= '0;
        else
            flags_r <= flags_nxt;
    end

    // Back-EMF path: sample during zero crossing, show at its end
    logic [7:0] scaled, held_r, held_nxt, bemf_r, bemf_nxt;
    logic zero_end;
    assign scaled = bemf_divider_sel ? {2'h0, coil_voltage_in[7:2]}
                                     : {1'h0, coil_voltage_in[7:1]};
    assign zero_end = |(zero_prev_r & ~zero_s); // Both coils, both signs
    always_comb begin
        held_nxt = (|zero_s && psh_s) ? scaled : held_r;
        if (bemf_transparent_sel)
            bemf_nxt = scaled;
        else
            bemf_nxt = zero_end ? held_r : bemf_r;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            held_r <= 8'h00;
            bemf_r <= 8'h00;
        end else begin
            held_r <= held_nxt;
            bemf_r <= bemf_nxt;
        end
    end

    // Outputs; the fault pin only ever pulls low
    assign speed_load_angle_out = bemf_r;
    assign fault_out_n = 1'b0;
    assign fault_out_n_oe = |flags_r;
    assign serial_data_out = tx_r[7];
    assign serial_data_out_oe = !cs_s;
    assign sleep_ctrl = cr2_r[`MSD_CR2_SLEEP];
    assign bemf_transparent_sel = cr2_r[`MSD_CR2_TRANS];
    assign bemf_divider_sel = cr2_r[`MSD_CR2_DIV];
    assign motor_enable = cr2_r[`MSD_CR2_MOTEN];
    assign ctrl0_out = cr0_r;
    assign ctrl1_out = cr1_r;
    // Any overcurrent or shutdown keeps bridges off
    assign drivers_hiz = sleep_ctrl || flags_r.therm_shut ||
                         (|flags_r.ovc_x) || (|flags_r.ovc_y);
    assign step_advance_out = step_s && !sleep_ctrl;
    assign rotation_sense_out = rot_s && !sleep_ctrl;
    assign clocks_run = !sleep_ctrl || !cs_s;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_dout_release: assert property (cs_rise |=> !serial_data_out_oe)
        else $error("data out driven after deselect");
    a_fault_pin: assert property ((|flags_r) |-> fault_out_n_oe)
        else $error("fault pin idle with flag set");
    a_ovc_stick: assert property (flags_r.ovc_x[0] && !st_clr_r[1]
        |=> flags_r.ovc_x[0] && drivers_hiz)
        else $error("overcurrent flag lost without clear");
    a_shut_hold: assert property (flags_r.therm_shut && warn_s
        |=> flags_r.therm_shut)
        else $error("shutdown flag cleared while still warm");
    a_write_commit: assert property (
        cs_rise && total_r == `MSD_WR_BITS && wr_first_r &&
        wr_addr_r == `MSD_IDX_CR2 |=> cr2_r == $past(wr_data_r))
        else $error("write data not committed");
    a_write_len: assert property (cs_rise && total_r != `MSD_WR_BITS
        |=> $stable(cr2_r) && $stable(cr0_r))
        else $error("odd length write changed a register");
    a_status_par: assert property (
        cs_s |-> !(^st0) && !(^st1) && !(^st2))
        else $error("status parity wrong");
    a_byte_load: assert property (
        !cs_s && sclk_fall && bit_r == 3'h0 && total_r != 6'h00
        ##1 !cs_rise |-> tx_r == $past(rd_byte))
        else $error("output byte not reloaded");
    a_sleep_step: assert property (sleep_ctrl |-> drivers_hiz &&
        !step_advance_out)
        else $error("step passed during sleep");
    a_bemf_track: assert property (bemf_transparent_sel [*2]
        |-> bemf_r == $past(scaled))
        else $error("transparent output not tracking");

endmodule
`default_nettype wire

// >>> verification/msd_spi_master.sv
// Purpose: serial master model driving the motor driver serial port
// Assumes: mode zero, 125 ns link clock period
// Notes: clock stands still low outside frames
`default_nettype none
module msd_spi_master (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus: select off, clock low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    // Full duplex packet of nbits, clock runs on without a pause between bytes
    task automatic xfer(input logic [31:0] tx, input int nbits,
                        output logic [31:0] rx);
        rx = '0;
        cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            mosi = tx[i];
            #62.5;
            sclk = 1'b1;
            rx = {rx[30:0], miso};
            #62.5;
            sclk = 1'b0;
        end
        #62.5;
        cs_n = 1'b1;
        // Released data line must not keep the last bit
        mosi = ~mosi;
        #250;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: self-checking bench of the serial port and fault flags
// Assumes: open coil count shortened to 50 cycles
// Notes: status reads clear flags, so reads are placed with care
`include "msd_defines.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0, srst, hard_reset_in, sclk_in, cs_n_in, serial_data_in;
    logic serial_data_out, serial_data_out_oe, thermal_warn_in;
    logic thermal_shutdown_in, full_duty_x_in, full_duty_y_in, pump_low_in;
    logic [3:0] overcurrent_x_in, overcurrent_y_in;
    logic [1:0] coil_zero_in;
    logic pwm_sample_hold, step_advance_in, rotation_sense_in;
    logic [7:0] coil_voltage_in, bemf_out, ctrl0_out, ctrl1_out, b, v;
    logic [6:0] step_position_in;
    logic fault_out_n, fault_out_n_oe, drivers_hiz, step_advance_out;
    logic rotation_sense_out, clocks_run, sleep_ctrl, bemf_transparent_sel;
    logic bemf_divider_sel, motor_enable;
    logic [31:0] rx;
    logic [7:0] cr [1:3];
    int n_errors = 0, compares = 0, seed;
    // Pull-ups on the released data line and fault pin
    wire miso = serial_data_out_oe ? serial_data_out : 1'b1;
    wire fault_pin = fault_out_n_oe ? fault_out_n : 1'b1;

    always #5 clk = ~clk;

    msd_spi_diag #(.OPEN_CYCLES(50)) u_msd_spi_diag (
        .clk(clk), .srst(srst), .hard_reset_in(hard_reset_in),
        .sclk_in(sclk_in), .cs_n_in(cs_n_in), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe),
        .thermal_warn_in(thermal_warn_in),
        .thermal_shutdown_in(thermal_shutdown_in),
        .overcurrent_x_in(overcurrent_x_in),
        .overcurrent_y_in(overcurrent_y_in), .full_duty_x_in(full_duty_x_in),
        .full_duty_y_in(full_duty_y_in), .pump_low_in(pump_low_in),
        .coil_zero_in(coil_zero_in), .pwm_sample_hold(pwm_sample_hold),
        .coil_voltage_in(coil_voltage_in), .step_position_in(step_position_in),
        .step_advance_in(step_advance_in),
        .rotation_sense_in(rotation_sense_in),
        .speed_load_angle_out(bemf_out),
        .fault_out_n(fault_out_n), .fault_out_n_oe(fault_out_n_oe),
        .drivers_hiz(drivers_hiz), .step_advance_out(step_advance_out),
        .rotation_sense_out(rotation_sense_out), .clocks_run(clocks_run),
        .sleep_ctrl(sleep_ctrl), .bemf_transparent_sel(bemf_transparent_sel),
        .bemf_divider_sel(bemf_divider_sel), .motor_enable(motor_enable),
        .ctrl0_out(ctrl0_out), .ctrl1_out(ctrl1_out)
    );

    msd_spi_master u_msd_spi_master (
        .sclk(sclk_in), .cs_n(cs_n_in), .mosi(serial_data_in), .miso(miso)
    );

    // Status byte: top bit set when low seven bits hold an odd count
    function automatic logic [7:0] par(input logic [6:0] d);
        return {^d, d};
    endfunction

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] d, input int n);
        u_msd_spi_master.xfer({16'h0, `MSD_CMD_WRITE, idx, d}, n, rx);
        tick(1); // Back onto the falling edge for the next stimulus
    endtask

    task automatic rd(input logic [4:0] idx, output logic [7:0] d);
        u_msd_spi_master.xfer({16'h0, `MSD_CMD_READ, idx, 8'h00}, 16, rx);
        d = rx[7:0];
        tick(6);
    endtask

    task automatic final_report;
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard well inside the cycle budget
    initial begin
        #600us;
        n_errors++;
        final_report();
    end

    initial begin
        seed = $urandom(15698);
        {srst, hard_reset_in, thermal_warn_in, thermal_shutdown_in} = 4'h8;
        {full_duty_x_in, full_duty_y_in, pump_low_in, pwm_sample_hold} = 4'h0;
        {overcurrent_x_in, overcurrent_y_in, coil_zero_in} = 10'h000;
        {step_advance_in, rotation_sense_in} = 2'h0;
        coil_voltage_in = 8'h00;
        step_position_in = 7'h00;
        tick(20);
        srst = 1'b0;
        tick(6);
        check("fault_idle", fault_pin, 1'b1);
        check("dout_idle", miso, 1'b1);
        // Random writes of all control registers, sleep kept off
        for (int i = 1; i <= 3; i++) begin
            cr[i] = 8'($urandom) & (i == 3 ? 8'hbf : 8'hff);
            wr(5'(i), cr[i], 16);
        end
        tick(6);
        check("ctrl0", ctrl0_out, cr[1]);
        check("ctrl1", ctrl1_out, cr[2]);
        check("ctrl2", {motor_enable, sleep_ctrl, bemf_divider_sel,
            bemf_transparent_sel}, cr[3][7:4]);
        // Chained reads: each byte shows the previously addressed register
        u_msd_spi_master.xfer({`MSD_CMD_READ, `MSD_IDX_CR0, `MSD_CMD_READ,
            `MSD_IDX_CR1, `MSD_CMD_READ, `MSD_IDX_CR2, 8'h00}, 32, rx);
        check("chain", rx[23:0], {cr[1], cr[2], cr[3]});
        // 15- and 17-clock frames (decoded as a read and an unknown command), read-only and unknown-command writes are refused
        wr(`MSD_IDX_CR0, ~cr[1], 15);
        wr(`MSD_IDX_CR0, ~cr[1], 17);
        u_msd_spi_master.xfer({16'h0, 3'h2, `MSD_IDX_CR1, ~cr[2]}, 16, rx);
        wr(`MSD_IDX_ST0, 8'h7f, 16);
        rd(5'h1f, b);
        check("unmapped", b, 8'h00);
        check("ctrl0_kept", ctrl0_out, cr[1]);
        check("ctrl1_kept", ctrl1_out, cr[2]);
        // Warning and pump fail latch, pump fail holds while low
        thermal_warn_in = 1'b1;
        pump_low_in = 1'b1;
        tick(8);
        thermal_warn_in = 1'b0;
        tick(4);
        check("fault_set", fault_pin, 1'b0);
        rd(`MSD_IDX_ST0, b);
        check("st0_warn_pf", b, par(7'h60));
        rd(`MSD_IDX_ST0, b);
        check("st0_pf", b, par(7'h20));
        pump_low_in = 1'b0;
        tick(4);
        rd(`MSD_IDX_ST0, b);
        check("fault_clr", fault_pin, 1'b1);
        // Full duty too short, then long enough on the second coil
        full_duty_x_in = 1'b1;
        tick(30);
        full_duty_x_in = 1'b0;
        full_duty_y_in = 1'b1;
        tick(45);
        check("open_early", fault_pin, 1'b1);
        tick(30);
        full_duty_y_in = 1'b0;
        check("open_kept", drivers_hiz, 1'b0);
        rd(`MSD_IDX_ST0, b);
        check("st0_open", b, par(7'h08));
        // Overcurrent on each side latches and blocks drivers
        for (int k = 0; k < 2; k++) begin
            v = 8'($urandom % 15 + 1);
            {overcurrent_x_in, overcurrent_y_in} = k ? {4'h0, v[3:0]}
                : {v[3:0], 4'h0};
            tick(8);
            {overcurrent_x_in, overcurrent_y_in} = 8'h00;
            tick(8);
            check("ovc_off", drivers_hiz, 1'b1);
            rd(k ? `MSD_IDX_ST2 : `MSD_IDX_ST1, b);
            check("ovc_st", b, par(k ? {1'b0, v[3:0], 2'b0}
                : {v[3:0], 3'b0}));
            check("ovc_on", drivers_hiz, 1'b0);
        end
        // Shutdown clears only when warning gone and read again
        {thermal_warn_in, thermal_shutdown_in} = 2'h3;
        tick(8);
        thermal_shutdown_in = 1'b0;
        rd(`MSD_IDX_ST2, b);
        check("st2_shut", b, par(7'h40));
        check("shut_hot", drivers_hiz, 1'b1);
        thermal_warn_in = 1'b0;
        tick(4);
        rd(`MSD_IDX_ST0, b);
        rd(`MSD_IDX_ST2, b);
        check("shut_cool", drivers_hiz, 1'b0);
        // Random translator positions in the last status byte
        repeat (4) begin
            step_position_in = 7'($urandom);
            tick(2);
            rd(`MSD_IDX_ST3, b);
            check("st3", b, par(step_position_in));
        end
        // Back-EMF output in all four transparency and divider modes
        for (int m = 0; m < 4; m++) begin
            wr(`MSD_IDX_CR2, {2'b00, m[1], m[0], 4'h0}, 16);
            v = 8'($urandom);
            tick(4);
            coil_zero_in = m[1] ? 2'b10 : 2'b01;
            pwm_sample_hold = 1'b1;
            coil_voltage_in = v;
            tick(6);
            {coil_zero_in, pwm_sample_hold} = 3'h0;
            tick(6);
            if (!m[0]) coil_voltage_in = ~v;
            tick(4);
            check("bemf", bemf_out, v >> (m[1] + 1));
        end
        // Sleep keeps registers against hard reset and gates step inputs
        wr(`MSD_IDX_CR2, 8'h40, 16);
        {step_advance_in, rotation_sense_in, hard_reset_in} = 3'h7;
        tick(20);
        hard_reset_in = 1'b0;
        tick(6);
        check("slp_hiz", drivers_hiz, 1'b1);
        check("slp_step", {step_advance_out, rotation_sense_out}, 0);
        check("slp_clk", clocks_run, 1'b0);
        rd(`MSD_IDX_CR0, b);
        rd(`MSD_IDX_CR0, b);
        check("slp_keep", b, cr[1]);
        wr(`MSD_IDX_CR2, 8'h00, 16);
        tick(6);
        check("wake", {drivers_hiz, step_advance_out, rotation_sense_out,
            clocks_run}, 4'h7);
        hard_reset_in = 1'b1;
        tick(20);
        hard_reset_in = 1'b0;
        tick(6);
        check("hrst", {ctrl0_out, ctrl1_out}, 16'h0000);
        check("oe_idle", serial_data_out_oe, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
